// ### shared/sss_pkg.sv
// constants for the status summary and service request block
// assumes one instrument clock; shared by design and bench
package sss_pkg;
  // command codes on the in-order command port
  typedef enum logic [3:0] {
    SSS_OP_RD_COND = 4'h0,
    SSS_OP_RD_EVT  = 4'h1,
    SSS_OP_RD_EN   = 4'h2,
    SSS_OP_WR_EN   = 4'h3,
    SSS_OP_CLS     = 4'h4,
    SSS_OP_PRESET  = 4'h5,
    SSS_OP_RD_STB  = 4'h6,
    SSS_OP_WR_SRE  = 4'h7,
    SSS_OP_RD_SRE  = 4'h8
  } sss_op_e;
  // group indices
  localparam logic [1:0] GRP_ALARM = 2'h0;
  localparam logic [1:0] GRP_QUES  = 2'h1;
  localparam logic [1:0] GRP_STD   = 2'h2;
  localparam logic [1:0] GRP_OPER  = 2'h3;
  localparam int         NUM_GRP   = 4;
  // summary byte bit positions
  localparam int BIT_ALARM = 1;
  localparam int BIT_QUES  = 3;
  localparam int BIT_MAV   = 4;
  localparam int BIT_STD   = 5;
  localparam int BIT_RQS   = 6;
  localparam int BIT_OPER  = 7;
  // bits of the summary byte that may feed the master summary
  localparam logic [7:0] SRE_MASK  = 8'hbf;
  // reset values
  localparam logic [7:0] STB_RST   = 8'h00;
  localparam logic [7:0] SRE_RST   = 8'h00;
endpackage : sss_pkg

// ### rtl/sss_status_summary.sv
// status summary and service request logic: four event/enable groups,
// summary byte, its enable mask, message-available flag and SRQ.
// assumes condition inputs and commands come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sss_status_summary #(
  parameter int W = 16
) (
  // clock, reset, enable
  input  wire  logic                  clock,
  input  wire  logic                  rst_b,
  input  wire  logic                  clk_en,
  // instrument conditions
  input  wire  logic [W-1:0]          alarm_cond,
  input  wire  logic [W-1:0]          ques_cond,
  input  wire  logic [W-1:0]          std_cond,
  input  wire  logic [W-1:0]          oper_cond,
  input  wire  logic                  buf_nonempty,
  input  wire  logic                  psc_clear,
  // in-order command port
  input  wire  logic                  cmd_valid,
  input  wire  sss_pkg::sss_op_e      cmd_op,
  input  wire  logic [1:0]            cmd_group,
  input  wire  logic [W-1:0]          cmd_wdata,
  output logic                        rsp_valid_ff,
  output logic [W-1:0]                rsp_data_ff,
  // serial poll and service request
  input  wire  logic                  spoll_req,
  output logic                        spoll_valid_ff,
  output logic [7:0]                  spoll_data_ff,
  output logic                        srq_ff,
  output logic [7:0]                  stb_ff
);

  if (W < 8 || W > 16) begin : g_chk
    $error("sss_status_summary: W must be 8..16");
  end

  logic [W-1:0] cond_ff [sss_pkg::NUM_GRP];
  logic [W-1:0] evt_ff  [sss_pkg::NUM_GRP];
  logic [W-1:0] en_ff   [sss_pkg::NUM_GRP];
  logic [7:0]   sre_ff;
  logic         mss_ff;
  logic         rqs_ff;
  logic [W-1:0] nxt_cond [sss_pkg::NUM_GRP];
  logic [W-1:0] nxt_evt  [sss_pkg::NUM_GRP];
  logic [W-1:0] nxt_en   [sss_pkg::NUM_GRP];
  logic [7:0]   nxt_sre;
  logic [7:0]   rst_sre;
  logic         nxt_rqs;
  logic         nxt_rsp_valid;
  logic [W-1:0] nxt_rsp_data;
  logic [7:0]   stb_rep;
  logic         mss;
  logic         rqs_rise;
  logic [W-1:0] cond_sel;

  function automatic logic [7:0] build_stb(input logic [3:0] sum, input logic mav, input logic rqs);
    logic [7:0] b;
    b = sss_pkg::STB_RST;
    b[sss_pkg::BIT_ALARM] = sum[sss_pkg::GRP_ALARM];
    b[sss_pkg::BIT_QUES]  = sum[sss_pkg::GRP_QUES];
    b[sss_pkg::BIT_MAV]   = mav;
    b[sss_pkg::BIT_STD]   = sum[sss_pkg::GRP_STD];
    b[sss_pkg::BIT_OPER]  = sum[sss_pkg::GRP_OPER];
    b[sss_pkg::BIT_RQS]   = rqs;
    return b;
  endfunction : build_stb

  wire cmd_go = cmd_valid;

  always_comb begin
    logic [3:0] sum;
    sum = 4'h0;
    nxt_cond[sss_pkg::GRP_ALARM] = alarm_cond;
    nxt_cond[sss_pkg::GRP_QUES]  = ques_cond;
    nxt_cond[sss_pkg::GRP_STD]   = std_cond;
    nxt_cond[sss_pkg::GRP_OPER]  = oper_cond;
    cond_sel = nxt_cond[cmd_group];
    for (int g = 0; g < sss_pkg::NUM_GRP; g++) begin
      sum[g] = |(evt_ff[g] & en_ff[g]);
      nxt_evt[g] = evt_ff[g];
      nxt_en[g]  = en_ff[g];
      if (cmd_go && cmd_op == sss_pkg::SSS_OP_CLS) begin
        nxt_evt[g] = '0;
      end
      if (cmd_go && cmd_op == sss_pkg::SSS_OP_RD_EVT && cmd_group == 2'(g)) begin
        nxt_evt[g] = '0;
      end
      nxt_evt[g] = nxt_evt[g] | nxt_cond[g];
      if (cmd_go && cmd_op == sss_pkg::SSS_OP_PRESET) begin
        nxt_en[g] = '0;
      end
      if (cmd_go && cmd_op == sss_pkg::SSS_OP_WR_EN && cmd_group == 2'(g)) begin
        nxt_en[g] = cmd_wdata;
      end
    end
    // message-available follows the buffer directly, so it drops only once the last byte leaves
    stb_rep = build_stb(sum, buf_nonempty, rqs_ff);
    mss = |(stb_rep & sre_ff & sss_pkg::SRE_MASK);
    rqs_rise = mss && !mss_ff;
    // a fresh rise beats a poll in the same cycle so no request is lost
    if (rqs_rise) begin
      nxt_rqs = 1'b1;
    end else if (spoll_req || !mss) begin
      nxt_rqs = 1'b0;
    end else begin
      nxt_rqs = rqs_ff;
    end
    // the mask survives power-up unless the power-on-clear setting asks otherwise
    rst_sre = psc_clear ? sss_pkg::SRE_RST : sre_ff;
    nxt_sre = sre_ff;
    if (cmd_go && cmd_op == sss_pkg::SSS_OP_WR_SRE) begin
      nxt_sre = cmd_wdata[7:0] & sss_pkg::SRE_MASK;
    end
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = '0;
    if (cmd_go) begin
      case (cmd_op)
        sss_pkg::SSS_OP_RD_COND: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = cond_ff[cmd_group];
        end
        sss_pkg::SSS_OP_RD_EVT: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = evt_ff[cmd_group];
        end
        sss_pkg::SSS_OP_RD_EN: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = en_ff[cmd_group];
        end
        sss_pkg::SSS_OP_RD_STB: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = W'(stb_rep);
        end
        sss_pkg::SSS_OP_RD_SRE: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = W'(sre_ff);
        end
        default: begin
          nxt_rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int g = 0; g < sss_pkg::NUM_GRP; g++) begin
        cond_ff[g] <= '0;
        evt_ff[g]  <= '0;
        en_ff[g]   <= '0;
      end
      sre_ff         <= rst_sre;
      mss_ff         <= 1'b0;
      rqs_ff         <= 1'b0;
      srq_ff         <= 1'b0;
      stb_ff         <= sss_pkg::STB_RST;
      rsp_valid_ff   <= 1'b0;
      rsp_data_ff    <= '0;
      spoll_valid_ff <= 1'b0;
      spoll_data_ff  <= sss_pkg::STB_RST;
    end else if (clk_en) begin
      for (int g = 0; g < sss_pkg::NUM_GRP; g++) begin
        cond_ff[g] <= nxt_cond[g];
        evt_ff[g]  <= nxt_evt[g];
        en_ff[g]   <= nxt_en[g];
      end
      sre_ff         <= nxt_sre;
      mss_ff         <= mss;
      rqs_ff         <= nxt_rqs;
      srq_ff         <= nxt_rqs;
      stb_ff         <= stb_rep;
      rsp_valid_ff   <= nxt_rsp_valid;
      rsp_data_ff    <= nxt_rsp_data;
      // poll is served from its own port, never waits behind commands
      spoll_valid_ff <= spoll_req;
      spoll_data_ff  <= stb_rep;
    end
  end

  sequence s_rise;
    clk_en && mss && !mss_ff;
  endsequence

  sequence s_poll_only;
    clk_en && spoll_req && !(mss && !mss_ff);
  endsequence

  a_evt_latch_alarm: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && |alarm_cond |=> (evt_ff[0] & $past(alarm_cond)) == $past(alarm_cond))
    else $error("alarm event did not latch");

  a_evt_query_clear: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_RD_EVT
    |=> rsp_valid_ff && evt_ff[$past(cmd_group)] == $past(cond_sel))
    else $error("event query did not clear and answer");

  a_cls_keeps_en: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_CLS
    |=> en_ff[1] == $past(en_ff[1]) && evt_ff[1] == $past(ques_cond))
    else $error("clear status wrong");

  a_preset_clears: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_PRESET |=> en_ff[2] == '0 && en_ff[3] == '0)
    else $error("preset did not clear enables");

  a_mav_follows: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en |=> stb_ff[sss_pkg::BIT_MAV] == $past(buf_nonempty))
    else $error("message available wrong");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
    stb_ff[0] == 1'b0 && stb_ff[2] == 1'b0 && spoll_data_ff[0] == 1'b0)
    else $error("reserved summary bit set");

  a_srq_rise: assert property (@(posedge clock) disable iff (!rst_b)
    s_rise |=> srq_ff ##0 (stb_rep[sss_pkg::BIT_RQS] || !clk_en))
    else $error("srq not raised on master summary rise");

  a_spoll_clear: assert property (@(posedge clock) disable iff (!rst_b)
    s_poll_only |=> !srq_ff && spoll_valid_ff)
    else $error("serial poll did not release srq");

  a_sre_write: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_WR_SRE
    |=> sre_ff == ($past(cmd_wdata[7:0]) & sss_pkg::SRE_MASK))
    else $error("summary mask write wrong");

  a_stb_no_clear: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && rqs_ff && mss && !spoll_req |=> rqs_ff)
    else $error("request dropped without poll");

  a_freeze_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !clk_en |=> evt_ff[3] == $past(evt_ff[3]) && sre_ff == $past(sre_ff) && srq_ff == $past(srq_ff))
    else $error("state moved while clock enable low");

  a_cond_live: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en |=> cond_ff[3] == $past(oper_cond))
    else $error("condition register not following input");

  a_no_srq_unmasked: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && (stb_rep & sre_ff & sss_pkg::SRE_MASK) == 8'h00 |=> !srq_ff)
    else $error("service request without enabled condition");

  a_poll_at_once: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && spoll_req |=> spoll_valid_ff && spoll_data_ff == $past(stb_rep))
    else $error("serial poll not answered next cycle");

  a_stb_query: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_RD_STB
    |=> rsp_valid_ff && rsp_data_ff == W'($past(stb_rep)))
    else $error("summary query differs from poll value");

  a_sum_clear: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && cmd_valid && cmd_op == sss_pkg::SSS_OP_RD_EVT
    && cmd_group == sss_pkg::GRP_QUES && ques_cond == '0
    |=> !stb_rep[sss_pkg::BIT_QUES])
    else $error("group summary kept after event query");

endmodule : sss_status_summary
`default_nettype wire

// ### testbench/sss_host.sv
// bus controller model: in-order commands and serial polls
// assumes one bench thread calls its tasks; pins move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module sss_host #(
  parameter int W = 16
) (
  // clock
  input  wire  logic              clock,
  // command port
  output var sss_pkg::sss_op_e    cmd_op,
  output logic                    cmd_valid,
  output logic [1:0]              cmd_group,
  output logic [W-1:0]            cmd_wdata,
  input  wire  logic              rsp_valid_ff,
  input  wire  logic [W-1:0]      rsp_data_ff,
  // serial poll
  output logic                    spoll_req,
  input  wire  logic              spoll_valid_ff,
  input  wire  logic [7:0]        spoll_data_ff,
  // watchdog
  output logic                    hung
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = sss_pkg::SSS_OP_RD_COND;
    cmd_group = 2'h0;
    cmd_wdata = '0;
    spoll_req = 1'b0;
    hung = 1'b0;
  end
  // masks go out as one weighted word
  task automatic xfer(input sss_pkg::sss_op_e op, input logic [1:0] grp, input logic [W-1:0] wd,
                      input bit want, output logic [W-1:0] rd);
    int i;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_group = grp;
    cmd_wdata = wd;
    @(negedge clock);
    cmd_valid = 1'b0;
    // released data is scrambled so a stale word never looks valid
    cmd_wdata = ~wd;
    rd = 'x;
    if (want) begin
      for (i = 0; i < 4 && rsp_valid_ff !== 1'b1; i++) @(negedge clock);
      if (i == 4) hung = 1'b1;
      rd = rsp_data_ff;
    end
  endtask : xfer
  task automatic poll(output logic [7:0] pd);
    int i;
    @(negedge clock);
    spoll_req = 1'b1;
    @(negedge clock);
    spoll_req = 1'b0;
    for (i = 0; i < 4 && spoll_valid_ff !== 1'b1; i++) @(negedge clock);
    if (i == 4) hung = 1'b1;
    pd = spoll_data_ff;
  endtask : poll
  // clear status, masks, then a sync query before relying on the request line
  task automatic setup_srq(input logic [W-1:0] en, input logic [W-1:0] sre);
    logic [W-1:0] r;
    xfer(sss_pkg::SSS_OP_CLS, 2'h0, '0, 0, r);
    xfer(sss_pkg::SSS_OP_WR_EN, sss_pkg::GRP_STD, en, 0, r);
    xfer(sss_pkg::SSS_OP_WR_SRE, 2'h0, sre, 0, r);
    xfer(sss_pkg::SSS_OP_RD_STB, 2'h0, '0, 1, r);
  endtask : setup_srq
endmodule : sss_host
`default_nettype wire

// ### testbench/sss_status_summary_test.sv
// self-checking bench for the status summary block
// assumes the host model in sss_host; stimulus on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module sss_status_summary_test;
  localparam int W = 16;
  logic clock = 0, rst_b = 0, clk_en = 1, buf_nonempty = 0, psc_clear = 1;
  logic [W-1:0] cond [4] = '{default: '0};
  logic cmd_valid, rsp_valid_ff, spoll_req, spoll_valid_ff, srq_ff, hung;
  sss_pkg::sss_op_e cmd_op;
  logic [1:0] cmd_group;
  logic [W-1:0] cmd_wdata, rsp_data_ff, r, v, m;
  logic [7:0] spoll_data_ff, stb_ff, pd;
  int miscompares = 0, n_checks = 0, seed, g;
  always #12.5 clock = ~clock;
  sss_status_summary #(.W(W)) dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .alarm_cond(cond[0]), .ques_cond(cond[1]), .std_cond(cond[2]), .oper_cond(cond[3]),
    .buf_nonempty(buf_nonempty), .psc_clear(psc_clear), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_group(cmd_group), .cmd_wdata(cmd_wdata), .rsp_valid_ff(rsp_valid_ff),
    .rsp_data_ff(rsp_data_ff), .spoll_req(spoll_req), .spoll_valid_ff(spoll_valid_ff),
    .spoll_data_ff(spoll_data_ff), .srq_ff(srq_ff), .stb_ff(stb_ff));
  sss_host #(.W(W)) host (.clock(clock), .cmd_op(cmd_op), .cmd_valid(cmd_valid),
    .cmd_group(cmd_group), .cmd_wdata(cmd_wdata), .rsp_valid_ff(rsp_valid_ff),
    .rsp_data_ff(rsp_data_ff), .spoll_req(spoll_req), .spoll_valid_ff(spoll_valid_ff),
    .spoll_data_ff(spoll_data_ff), .hung(hung));
  // summary byte from group summaries, message flag and request flag
  function automatic logic [7:0] stb_of(input logic [3:0] s, input logic mav, input logic rqs);
    return {s[3], rqs, s[2], mav, s[1], 1'b0, s[0], 1'b0};
  endfunction : stb_of
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  task automatic rst_pulse;
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
  endtask : rst_pulse
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  always @(posedge hung) begin
    miscompares++;
    report_and_stop();
  end
  initial begin
    seed = 32'h3f31d23f;
    idle(20);
    rst_b = 1'b1;
    `CHK(stb_ff, 8'h00)
    for (g = 0; g < 4; g++) begin
      v = W'($random(seed) | 1);
      // group 1 gets an all-off mask: events must stay out of the summary
      m = (g == 1) ? '0 : W'($random(seed));
      host.xfer(sss_pkg::SSS_OP_WR_EN, g[1:0], m, 0, r);
      host.xfer(sss_pkg::SSS_OP_RD_EN, g[1:0], '0, 1, r);
      `CHK(r, m)
      cond[g] = v;
      idle(1);
      cond[g] = '0;
      idle(3);
      `CHK(stb_ff, stb_of(4'(|(v & m)) << g, 0, 0))
      host.xfer(sss_pkg::SSS_OP_RD_EVT, g[1:0], '0, 1, r);
      `CHK(r, v)
      host.xfer(sss_pkg::SSS_OP_RD_EVT, g[1:0], '0, 1, r);
      `CHK(r, '0)
      idle(3);
      `CHK(stb_ff, 8'h00)
      cond[g] = v;
      repeat (2) begin
        host.xfer(sss_pkg::SSS_OP_RD_COND, g[1:0], '0, 1, r);
        `CHK(r, v)
      end
      repeat (2) begin
        host.xfer(sss_pkg::SSS_OP_RD_EVT, g[1:0], '0, 1, r);
        `CHK(r, v)
      end
      cond[g] = '0;
      host.xfer(sss_pkg::SSS_OP_CLS, 2'h0, '0, 0, r);
      idle(3);
      `CHK(stb_ff, 8'h00)
      host.xfer(sss_pkg::SSS_OP_RD_EVT, g[1:0], '0, 1, r);
      `CHK(r, '0)
      host.xfer(sss_pkg::SSS_OP_RD_EN, g[1:0], '0, 1, r);
      `CHK(r, m)
      host.xfer(sss_pkg::SSS_OP_PRESET, 2'h0, '0, 0, r);
      host.xfer(sss_pkg::SSS_OP_RD_EN, g[1:0], '0, 1, r);
      `CHK(r, '0)
    end
    buf_nonempty = 1'b1;
    idle(3);
    `CHK(stb_ff, 8'h10)
    host.setup_srq(16'h0001, 16'h0020);
    `CHK(srq_ff, 1'b0)
    cond[2] = 16'h0001;
    idle(1);
    cond[2] = '0;
    idle(4);
    `CHK(srq_ff, 1'b1)
    `CHK(stb_ff, stb_of(4'h4, 1, 1))
    host.xfer(sss_pkg::SSS_OP_RD_STB, 2'h0, '0, 1, r);
    `CHK(r, 16'h0070)
    `CHK(srq_ff, 1'b1)
    host.poll(pd);
    `CHK(pd, 8'h70)
    `CHK(srq_ff, 1'b0)
    idle(2);
    `CHK(stb_ff, 8'h30)
    host.xfer(sss_pkg::SSS_OP_RD_EVT, sss_pkg::GRP_STD, '0, 1, r);
    idle(3);
    `CHK(stb_ff, 8'h10)
    buf_nonempty = 1'b0;
    idle(3);
    `CHK(stb_ff, 8'h00)
    host.xfer(sss_pkg::SSS_OP_WR_SRE, 2'h0, '0, 0, r);
    host.xfer(sss_pkg::SSS_OP_RD_SRE, 2'h0, '0, 1, r);
    `CHK(r, '0)
    host.xfer(sss_pkg::SSS_OP_WR_SRE, 2'h0, 16'h0020, 0, r);
    psc_clear = 1'b0;
    rst_pulse();
    host.xfer(sss_pkg::SSS_OP_RD_SRE, 2'h0, '0, 1, r);
    `CHK(r, 16'h0020)
    psc_clear = 1'b1;
    rst_pulse();
    host.xfer(sss_pkg::SSS_OP_RD_SRE, 2'h0, '0, 1, r);
    `CHK(r, '0)
    // clock enable low: a pulse, a write and a buffer change must all be missed
    clk_en = 1'b0;
    cond[3] = 16'h0004;
    buf_nonempty = 1'b1;
    host.xfer(sss_pkg::SSS_OP_WR_EN, sss_pkg::GRP_OPER, 16'h0004, 0, r);
    idle(2);
    `CHK(stb_ff, 8'h00)
    cond[3] = '0;
    buf_nonempty = 1'b0;
    clk_en = 1'b1;
    host.xfer(sss_pkg::SSS_OP_RD_EVT, sss_pkg::GRP_OPER, '0, 1, r);
    `CHK(r, '0)
    host.xfer(sss_pkg::SSS_OP_RD_EN, sss_pkg::GRP_OPER, '0, 1, r);
    `CHK(r, '0)
    report_and_stop();
  end
endmodule : sss_status_summary_test
`default_nettype wire
